// file: pulse_timer_cfg.svh
// constants for the pulse timer unit counter core: offsets, fields, reset values
`ifndef PULSE_TIMER_CFG_SVH
`define PULSE_TIMER_CFG_SVH

// ---------------------------------------------------------------
// sizes
// ---------------------------------------------------------------
`define PTU_NCH          4
`define PTU_CNT_W        16
`define PTU_ADDR_W       12
`define PTU_NFLAG        5

// ---------------------------------------------------------------
// global register byte offsets
// ---------------------------------------------------------------
`define PTU_OFF_START    12'h000
`define PTU_OFF_SYNC     12'h004
`define PTU_OFF_STATUS   12'h008
`define PTU_OFF_INTEN    12'h00C

// ---------------------------------------------------------------
// per channel window: base, stride bits, word index inside it
// ---------------------------------------------------------------
`define PTU_CH_REGION    5'h02
`define PTU_REG_CTRL     3'h0
`define PTU_REG_COUNT    3'h1
`define PTU_REG_GRA      3'h2
`define PTU_REG_GRB      3'h3
`define PTU_REG_GRC      3'h4
`define PTU_REG_GRD      3'h5

// ---------------------------------------------------------------
// control field positions and codes
// ---------------------------------------------------------------
`define PTU_CTL_PHASE    0
`define PTU_CTL_BUFC     1
`define PTU_CTL_BUFD     2
`define PTU_CTL_CLR_LO   5
`define PTU_CTL_CLR_HI   6
`define PTU_CLR_NONE     2'h0
`define PTU_CLR_GRA      2'h1
`define PTU_CLR_GRB      2'h2
`define PTU_CLR_SYNC     2'h3

// ---------------------------------------------------------------
// status / enable flag positions inside each channel byte
// ---------------------------------------------------------------
`define PTU_FLG_MATCHA   0
`define PTU_FLG_MATCHB   1
`define PTU_FLG_MATCHC   2
`define PTU_FLG_MATCHD   3
`define PTU_FLG_OVF      4
`define PTU_FLG_STRIDE   8

// ---------------------------------------------------------------
// reset and boundary values
// ---------------------------------------------------------------
`define PTU_CNT_MAX      16'hFFFF
`define PTU_CNT_ZERO     16'h0000

`endif

// file: pulse_timer_pkg.sv
// types shared by the pulse timer unit counter core
package pulse_timer_pkg;
	`include "pulse_timer_cfg.svh"

	typedef logic [`PTU_CNT_W-1:0] count_t;

	typedef struct packed {
		logic [1:0]   clrSrc;     // clear_source_bit1/bit0
		logic         bufD;       // general_reg_d used as buffer
		logic         bufC;       // general_reg_c used as buffer
		logic         phaseMode;  // phase counting mode 2
		count_t       count;      // timer_count
		count_t [3:0] genReg;     // general_reg_a .. general_reg_d
	} chan_t;

	typedef logic [`PTU_NFLAG-1:0] flags_t;

	typedef struct packed {
		chan_t  [`PTU_NCH-1:0] chan;
		logic   [`PTU_NCH-1:0] startBits;  // channel_start_reg
		logic   [`PTU_NCH-1:0] syncBits;   // synchronisation_reg
		flags_t [`PTU_NCH-1:0] status;     // channel_status_reg
		flags_t [`PTU_NCH-1:0] inten;      // interrupt_enable_reg
		logic   [3:0]          pinS1;      // synchroniser stage 1
		logic   [3:0]          pinS2;      // synchroniser stage 2
		logic   [3:0]          pinS3;      // synchroniser stage 3
		logic   [3:0]          pinLvl;     // accepted pin level
		logic   [3:0]          pinPrev;    // level one cycle earlier
		logic   [31:0]         rdata;      // read data register
	} state_t;
endpackage : pulse_timer_pkg

// file: pulse_timer_core.sv
// counter core of the pulse timer unit: four channels, apb registers, interrupt
//
// Behaviour
// - clear source: none, reg A, reg B, sync
// - control bit 7 above the clear field reads zero always
// - sync clearing needs channel sync bit set
// - buffered C/D registers give no match
// - after reset counters are free-running but stopped
// - counting starts when start bit set
// - wrap FFFF to 0000 sets overflow flag
// - enabled overflow flag raises interrupt request
// - after overflow count continues from zero
// - compare clearing makes channel a periodic counter
// - count equal period sets flag, clears count
// - enabled match flag raises interrupt request
// - channels 0,3 use A/B; 1,2 use C/D
// - phase mode 2: A falls, B sets direction
`timescale 1ns/1ps

`include "pulse_timer_cfg.svh"

module pulse_timer_core
	import pulse_timer_pkg::*;
(
	input  wire logic        ref_clk,     // 40 MHz clock
	input  wire logic        reset_n,     // async reset, active low
	input  wire logic [11:0] paddr,       // apb byte address
	input  wire logic        psel,        // apb select
	input  wire logic        penable,     // apb access phase
	input  wire logic        pwrite,      // apb write
	input  wire logic [31:0] pwdata,      // apb write data
	input  wire logic [3:0]  pstrb,       // apb byte strobes
	output logic      [31:0] prdata,      // apb read data
	output logic             pready,      // apb ready
	output logic             pslverr,     // apb error on unmapped address
	input  wire logic        extClockA,   // ext_clock_a phase pin
	input  wire logic        extClockB,   // ext_clock_b phase pin
	input  wire logic        extClockC,   // ext_clock_c phase pin
	input  wire logic        extClockD,   // ext_clock_d phase pin
	output logic             irq          // level interrupt request
);

	// ---------------------------------------------------------------
	// decode helpers
	// ---------------------------------------------------------------

	// address falls in the per channel window
	function automatic logic isChanAddr(input logic [11:0] a);
		isChanAddr = (a[11:7] == `PTU_CH_REGION) && (a[4:2] <= `PTU_REG_GRD) && (a[1:0] == 2'h0);
	endfunction : isChanAddr

	// address is any mapped register
	function automatic logic isMapped(input logic [11:0] a);
		isMapped = isChanAddr(a) || (a == `PTU_OFF_START) || (a == `PTU_OFF_SYNC)
			|| (a == `PTU_OFF_STATUS) || (a == `PTU_OFF_INTEN);
	endfunction : isMapped

	// index 0 of the phase pair is A/B, index 1 is C/D
	function automatic logic pairOf(input int ch);
		pairOf = (ch == 1) || (ch == 2);
	endfunction : pairOf

	// pack per channel flags into byte lanes
	function automatic logic [31:0] packFlags(input flags_t [`PTU_NCH-1:0] f);
		logic [31:0] w;
		w = 32'h0000_0000;
		for (int i = 0; i < `PTU_NCH; i++)
		begin
			w[i*`PTU_FLG_STRIDE +: `PTU_NFLAG] = f[i];
		end
		packFlags = w;
	endfunction : packFlags

	// unpack byte lanes into per channel flags
	function automatic flags_t [`PTU_NCH-1:0] unpackFlags(input logic [31:0] w);
		flags_t [`PTU_NCH-1:0] f;
		for (int i = 0; i < `PTU_NCH; i++)
		begin
			f[i] = w[i*`PTU_FLG_STRIDE +: `PTU_NFLAG];
		end
		unpackFlags = f;
	endfunction : unpackFlags

	// merge a write under byte strobes
	function automatic logic [31:0] strobeMerge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] st);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++)
		begin
			if (st[b])
			begin
				m[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		strobeMerge = m;
	endfunction : strobeMerge

	// read view of one register
	function automatic logic [31:0] readWord(input state_t st, input logic [11:0] a);
		logic [31:0] r;
		logic [1:0]  c;
		r = 32'h0000_0000;
		c = a[6:5];
		if (isChanAddr(a))
		begin
			case (a[4:2])
				`PTU_REG_CTRL:
				begin
					// bit 7 is not stored and reads as zero
					r[`PTU_CTL_CLR_HI:`PTU_CTL_CLR_LO] = st.chan[c].clrSrc;
					r[`PTU_CTL_PHASE] = st.chan[c].phaseMode;
					r[`PTU_CTL_BUFC]  = st.chan[c].bufC;
					r[`PTU_CTL_BUFD]  = st.chan[c].bufD;
				end
				`PTU_REG_COUNT: r[15:0] = st.chan[c].count;
				`PTU_REG_GRA:   r[15:0] = st.chan[c].genReg[0];
				`PTU_REG_GRB:   r[15:0] = st.chan[c].genReg[1];
				`PTU_REG_GRC:   r[15:0] = st.chan[c].genReg[2];
				`PTU_REG_GRD:   r[15:0] = st.chan[c].genReg[3];
				default:        r = 32'h0000_0000;
			endcase
		end
		else if (a == `PTU_OFF_START)
		begin
			r[`PTU_NCH-1:0] = st.startBits;
		end
		else if (a == `PTU_OFF_SYNC)
		begin
			r[`PTU_NCH-1:0] = st.syncBits;
		end
		else if (a == `PTU_OFF_STATUS)
		begin
			r = packFlags(st.status);
		end
		else if (a == `PTU_OFF_INTEN)
		begin
			r = packFlags(st.inten);
		end
		readWord = r;
	endfunction : readWord

	// ---------------------------------------------------------------
	// reset release
	// ---------------------------------------------------------------
	logic   rstMeta;
	logic   rstSync;
	state_t s;
	state_t next_s;

	// two flops release reset synchronously
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rstMeta <= 1'b0;
			rstSync <= 1'b0;
		end
		else
		begin
			rstMeta <= 1'b1;
			rstSync <= rstMeta;
		end
	end

	// ---------------------------------------------------------------
	// bus handshake and outputs
	// ---------------------------------------------------------------
	logic busWrite;
	logic [31:0] wWord;

	// zero wait state answer, read data latched in the setup cycle
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !isMapped(paddr);
	assign busWrite = psel && penable && pwrite && isMapped(paddr);
	assign wWord    = strobeMerge(readWord(s, paddr), pwdata, pstrb);
	assign prdata   = s.rdata;

	// level interrupt from unmasked sticky flags
	always_comb
	begin
		irq = 1'b0;
		for (int i = 0; i < `PTU_NCH; i++)
		begin
			irq = irq | (|(s.status[i] & s.inten[i]));
		end
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb
	begin
		logic [`PTU_NCH-1:0] running;
		logic [`PTU_NCH-1:0] ownClr;
		logic [`PTU_NCH-1:0] clr;
		logic [`PTU_NCH-1:0] up;
		logic [`PTU_NCH-1:0] dn;
		flags_t [`PTU_NCH-1:0] ev;
		flags_t [`PTU_NCH-1:0] w1c;
		logic [3:0] fall;
		logic syncClr;
		logic pa;
		logic pb;
		logic [1:0] c;
		running = '0;
		ownClr  = '0;
		clr     = '0;
		up      = '0;
		dn      = '0;
		ev      = '0;
		w1c     = '0;
		fall    = 4'h0;
		syncClr = 1'b0;
		pa      = 1'b0;
		pb      = 1'b0;
		c       = paddr[6:5];
		next_s  = s;

		// phase pins: three stages, accept when stages two and three agree
		next_s.pinS1 = {extClockD, extClockC, extClockB, extClockA};
		next_s.pinS2 = s.pinS1;
		next_s.pinS3 = s.pinS2;
		for (int p = 0; p < 4; p++)
		begin
			if (s.pinS2[p] == s.pinS3[p])
			begin
				next_s.pinLvl[p] = s.pinS3[p];
			end
		end
		next_s.pinPrev = s.pinLvl;
		fall = s.pinPrev & ~s.pinLvl;

		// per channel compare events and own clearing
		for (int i = 0; i < `PTU_NCH; i++)
		begin
			running[i] = s.startBits[i];
			ev[i][`PTU_FLG_MATCHA] = running[i] && (s.chan[i].count == s.chan[i].genReg[0]);
			ev[i][`PTU_FLG_MATCHB] = running[i] && (s.chan[i].count == s.chan[i].genReg[1]);
			ev[i][`PTU_FLG_MATCHC] = running[i] && !s.chan[i].bufC
				&& (s.chan[i].count == s.chan[i].genReg[2]);
			ev[i][`PTU_FLG_MATCHD] = running[i] && !s.chan[i].bufD
				&& (s.chan[i].count == s.chan[i].genReg[3]);
			// clearing from A or B makes the channel periodic
			ownClr[i] = ((s.chan[i].clrSrc == `PTU_CLR_GRA) && ev[i][`PTU_FLG_MATCHA])
				|| ((s.chan[i].clrSrc == `PTU_CLR_GRB) && ev[i][`PTU_FLG_MATCHB]);
			syncClr = syncClr | (ownClr[i] && s.syncBits[i]);
		end

		// final clear, direction and count update
		for (int i = 0; i < `PTU_NCH; i++)
		begin
			clr[i] = ownClr[i] || ((s.chan[i].clrSrc == `PTU_CLR_SYNC) && s.syncBits[i] && syncClr);
			pa = pairOf(i) ? fall[2] : fall[0]; // falling edge of phase A
			pb = pairOf(i) ? s.pinLvl[3] : s.pinLvl[1];
			if (s.chan[i].phaseMode)
			begin
				up[i] = running[i] && pa && pb;
				dn[i] = running[i] && pa && !pb;
			end
			else
			begin
				up[i] = running[i];
			end
			if (clr[i])
			begin
				next_s.chan[i].count = `PTU_CNT_ZERO;
			end
			else if (up[i])
			begin
				next_s.chan[i].count = s.chan[i].count + 16'h0001;
				ev[i][`PTU_FLG_OVF] = (s.chan[i].count == `PTU_CNT_MAX);
			end
			else if (dn[i])
			begin
				next_s.chan[i].count = s.chan[i].count - 16'h0001;
			end
		end

		// bus writes; a counting write to the same count loses to software
		if (busWrite)
		begin
			if (isChanAddr(paddr))
			begin
				case (paddr[4:2])
					`PTU_REG_CTRL:
					begin
						next_s.chan[c].clrSrc    = wWord[`PTU_CTL_CLR_HI:`PTU_CTL_CLR_LO];
						next_s.chan[c].phaseMode = wWord[`PTU_CTL_PHASE];
						next_s.chan[c].bufC      = wWord[`PTU_CTL_BUFC];
						next_s.chan[c].bufD      = wWord[`PTU_CTL_BUFD];
					end
					`PTU_REG_COUNT: next_s.chan[c].count     = wWord[15:0];
					`PTU_REG_GRA:   next_s.chan[c].genReg[0] = wWord[15:0];
					`PTU_REG_GRB:   next_s.chan[c].genReg[1] = wWord[15:0];
					`PTU_REG_GRC:   next_s.chan[c].genReg[2] = wWord[15:0];
					`PTU_REG_GRD:   next_s.chan[c].genReg[3] = wWord[15:0];
					default:        next_s.chan[c].count     = next_s.chan[c].count;
				endcase
			end
			else if (paddr == `PTU_OFF_START)
			begin
				next_s.startBits = wWord[`PTU_NCH-1:0];
			end
			else if (paddr == `PTU_OFF_SYNC)
			begin
				next_s.syncBits = wWord[`PTU_NCH-1:0];
			end
			else if (paddr == `PTU_OFF_STATUS)
			begin
				w1c = unpackFlags(pwdata & {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}});
			end
			else if (paddr == `PTU_OFF_INTEN)
			begin
				next_s.inten = unpackFlags(wWord);
			end
		end

		// sticky flags: a new event wins over a write-one clear
		for (int i = 0; i < `PTU_NCH; i++)
		begin
			next_s.status[i] = (s.status[i] & ~w1c[i]) | ev[i];
		end

		// read data captured in the setup cycle
		if (psel && !penable && !pwrite)
		begin
			next_s.rdata = readWord(s, paddr);
		end
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstSync)
	begin
		if (!rstSync)
		begin
			s <= '0; // clear source none, all stopped
		end
		else
		begin
			s <= next_s;
		end
	end

endmodule : pulse_timer_core

// file: pulse_timer_monitor.sv
// port checker for the pulse timer core
`timescale 1ns/1ps

module pulse_timer_monitor
	import pulse_timer_pkg::*;
(
	input wire logic        ref_clk,  // clock
	input wire logic        reset_n,  // reset, active low
	input wire logic [11:0] paddr,    // address
	input wire logic        psel,     // select
	input wire logic        penable,  // access phase
	input wire logic        pwrite,   // write
	input wire logic [31:0] pwdata,   // write data
	input wire logic [3:0]  pstrb,    // strobes
	input wire logic [31:0] prdata,   // read data
	input wire logic        pready,   // ready
	input wire logic        pslverr,  // error
	input wire logic        irq       // interrupt
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	// access decode
	logic acc;
	logic rdAcc;
	logic chWin;
	assign acc = psel && penable;
	assign rdAcc = acc && !pwrite;
	assign chWin = paddr[11:7] == 5'h02;

	a_ready_high: assert property (acc |-> pready)
		else $error("pready low in access");
	a_err_access: assert property (pslverr |-> acc)
		else $error("pslverr outside access");
	a_err_unaligned: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unaligned access not refused");
	a_err_mapped: assert property (acc && paddr[11:4] == 8'h00 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("mapped access refused");
	a_ctrl_reserved: assert property (rdAcc && chWin && paddr[4:0] == 5'h00 |-> prdata[31:7] == 25'h0)
		else $error("control reserved bits read nonzero");
	a_count_width: assert property (rdAcc && chWin && paddr[4:0] == 5'h04 |-> prdata[31:16] == 16'h0)
		else $error("count wider than 16 bits");
	a_status_layout: assert property (rdAcc && paddr == 12'h008 |-> (prdata & 32'hE0E0E0E0) == 32'h0)
		else $error("status unused bits set");
	a_irq_masked: assert property (acc && pwrite && paddr == 12'h00C && pstrb == 4'hF && pwdata == 32'h0 |=> !irq)
		else $error("irq high with all enables off");
	a_irq_fall: assert property ($fell(irq) |-> $past(acc && pwrite && (paddr == 12'h008 || paddr == 12'h00C)))
		else $error("irq fell without a write");
	a_rdata_hold: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
		else $error("prdata changed outside read setup");

	c_irq: cover property ($rose(irq));
	c_err: cover property (acc && pslverr);
	c_irq_fall: cover property ($fell(irq));
endmodule : pulse_timer_monitor

bind pulse_timer_core pulse_timer_monitor mon_u (.ref_clk(ref_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .irq(irq));

// file: phase_pin_model.sv
// model of an external quadrature source on one phase pin pair
`timescale 1ns/1ps

module phase_pin_model
(
	input wire logic ref_clk,  // clock
	output logic     phaseA,   // phase A pin
	output logic     phaseB    // phase B pin
);
	// idle with A high so no falling edge shows at start
	initial
	begin
		phaseA = 1'b1;
		phaseB = 1'b0;
	end

	// B sets direction, A falls and rises, then B moves while A is steady
	task automatic step(input logic up, input int gap);
		phaseB <= up;
		repeat (gap) @(posedge ref_clk);
		phaseA <= 1'b0;
		repeat (gap) @(posedge ref_clk);
		phaseA <= 1'b1;
		repeat (gap) @(posedge ref_clk);
		phaseB <= ~up;
		repeat (gap) @(posedge ref_clk);
	endtask : step
endmodule : phase_pin_model

// file: testbench.sv
// self-checking testbench for the pulse timer core
`timescale 1ns/1ps

module testbench;
	import pulse_timer_pkg::*;
	logic        ref_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'hF;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        pinA, pinB, pinC, pinD;
	logic [31:0] rdat;
	logic        errSeen;
	int          failures = 0;
	int          n_tests = 0;

	// 40 MHz clock
	always #12.5 ref_clk = ~ref_clk;

	pulse_timer_core dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.extClockA(pinA), .extClockB(pinB), .extClockC(pinC), .extClockD(pinD), .irq(irq));
	phase_pin_model abPins (.ref_clk(ref_clk), .phaseA(pinA), .phaseB(pinB));
	phase_pin_model cdPins (.ref_clk(ref_clk), .phaseA(pinC), .phaseB(pinD));

	// one apb transfer; data and error taken at the ready edge
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rdat = prdata;
		errSeen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// byte address of a channel register
	function automatic logic [11:0] ch(input int i, input int r);
		return 12'(32'h100 + i * 32 + r * 4);
	endfunction : ch

	// verdict and end of run
	task automatic results();
		if (failures == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results

	// hang guard
	initial
	begin
		#400000;
		failures++;
		results();
	end

	// test sequence
	initial
	begin
		repeat (10) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		xfer(0, ch(0, 0), 0);
		chk(rdat, 32'h0);
		repeat (20) @(posedge ref_clk);
		xfer(0, ch(0, 1), 0);
		chk(rdat, 32'h0);
		xfer(1, ch(1, 0), 32'hE7);
		xfer(0, ch(1, 0), 0);
		chk(rdat, 32'h67);
		xfer(0, 12'hF00, 0);
		chk({31'h0, errSeen}, 32'h1);
		xfer(0, 12'h006, 0);
		chk({31'h0, errSeen}, 32'h1);
		// overflow with interrupt masked, then enabled, then cleared
		xfer(1, ch(1, 0), 0);
		xfer(1, ch(0, 1), 32'hFFF8);
		xfer(1, 12'h000, 32'h1);
		repeat (20) @(posedge ref_clk);
		xfer(0, 12'h008, 0);
		chk({31'h0, rdat[4]}, 32'h1);
		chk({31'h0, irq}, 32'h0);
		xfer(0, ch(0, 1), 0);
		chk({31'h0, rdat < 32'h40}, 32'h1);
		xfer(1, 12'h00C, 32'h10);
		@(posedge ref_clk);
		chk({31'h0, irq}, 32'h1);
		xfer(1, 12'h000, 0);
		xfer(1, 12'h008, 32'hFFFFFFFF);
		@(posedge ref_clk);
		chk({31'h0, irq}, 32'h0);
		xfer(1, 12'h00C, 0);
		// periodic count cleared by register A, then by register B
		for (int k = 1; k <= 2; k++)
		begin
			xfer(1, ch(1, 2), k == 1 ? 32'h9 : 32'h7000);
			xfer(1, ch(1, 3), k == 2 ? 32'h9 : 32'h7000);
			xfer(1, ch(1, 1), 0);
			xfer(1, ch(1, 0), 32'(k) << 5);
			xfer(1, 12'h000, 32'h2);
			repeat (6)
			begin
				xfer(0, ch(1, 1), 0);
				chk({31'h0, rdat < 32'hA}, 32'h1);
			end
			xfer(1, 12'h00C, 32'h100);
			@(posedge ref_clk);
			chk({31'h0, irq}, {31'h0, k == 1});
			xfer(1, 12'h000, 0);
			xfer(0, 12'h008, 0);
			chk({30'h0, rdat[9:8]}, 32'(k));
			xfer(1, 12'h00C, 0);
			xfer(1, 12'h008, 32'hFFFFFFFF);
		end
		// byte strobes limit a write to the enabled lanes
		pstrb <= 4'h2;
		xfer(1, 12'h00C, 32'hFFFFFFFF);
		pstrb <= 4'hF;
		xfer(0, 12'h00C, 0);
		chk(rdat, 32'h0000_1F00);
		xfer(1, 12'h00C, 0);
		// synchronous clearing only where the sync bit is set
		xfer(1, ch(0, 2), 32'h9);
		xfer(1, ch(0, 0), 32'h20);
		xfer(1, ch(2, 0), 32'h60);
		xfer(1, ch(3, 0), 32'h60);
		xfer(1, ch(0, 1), 0);
		xfer(1, ch(2, 1), 0);
		xfer(1, ch(3, 1), 0);
		xfer(1, 12'h004, 32'h9);
		xfer(1, 12'h000, 32'hD);
		repeat (40) @(posedge ref_clk);
		xfer(0, ch(3, 1), 0);
		chk({31'h0, rdat < 32'hA}, 32'h1);
		xfer(0, ch(2, 1), 0);
		chk({31'h0, rdat > 32'h9}, 32'h1);
		xfer(1, 12'h000, 0);
		// a buffered C or D register gives no match, the other one still matches
		for (int b = 1; b <= 2; b++)
		begin
			xfer(1, ch(1, 0), 32'(b) << 1);
			xfer(1, ch(1, 4), 32'h5);
			xfer(1, ch(1, 5), 32'h5);
			xfer(1, ch(1, 1), 0);
			xfer(1, 12'h008, 32'hFFFFFFFF);
			xfer(1, 12'h000, 32'h2);
			repeat (20) @(posedge ref_clk);
			xfer(1, 12'h000, 0);
			xfer(0, 12'h008, 0);
			chk({30'h0, rdat[11:10]}, 32'(3 - b));
		end
		// phase counting on both pin pairs
		xfer(1, ch(0, 0), 32'h1);
		xfer(1, ch(1, 0), 32'h1);
		xfer(1, ch(0, 1), 32'h10);
		xfer(1, ch(1, 1), 32'h10);
		xfer(1, 12'h000, 32'h3);
		for (int j = 0; j < 4; j++)
			abPins.step(j != 3, j == 3 ? 12 : 6);
		cdPins.step(1'b0, 6);
		xfer(0, ch(0, 1), 0);
		chk(rdat, 32'h12);
		xfer(0, ch(1, 1), 0);
		chk(rdat, 32'hF);
		results();
	end
endmodule : testbench
